/* src/pio_pkg.sv */
package pio_pkg;

  // ****************************************
  // register map (byte addresses = high index * 32 + index * 4)
  // ****************************************
  localparam logic [2:0] IDX_GEN_DATA = 3'h0;
  localparam logic [2:0] IDX_NIB_DATA = 3'h1;
  localparam logic [2:0] IDX_ANA_DATA = 3'h2;
  localparam logic [2:0] IDX_TMR_DATA = 3'h3;
  localparam logic [2:0] IDX_GEN_DIR = 3'h4;
  localparam logic [2:0] IDX_NIB_DIR = 3'h5;
  localparam logic [2:0] IDX_ANA_DIR = 3'h6;
  localparam logic [2:0] IDX_TMR_DIR = 3'h7;
  localparam logic [2:0] IDX_CONV_CTL = 3'h0;
  localparam logic [7:0] IDX_ADDR_HI_MAP = 8'h00;
  localparam logic [7:0] IDX_ADDR_HI_CONV = 8'h01;
  localparam int ADDR_W = 12;

  // ****************************************
  // field layouts
  // ****************************************
  localparam logic [7:0] NIB_MASK = 8'hf0;
  localparam logic [7:0] TMR_MASK = 8'hc0;
  localparam logic [7:0] TMR_DIR_MASK = 8'h40;
  localparam logic [7:0] ANA_REF_MASK = 8'hc0;
  localparam logic [3:0] ANA_PIN_CHANS = 4'h6;
  localparam int CONV_EN_BIT = 5;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] gen;
    logic [7:0] nib;
    logic [7:0] ana;
    logic [7:0] tmr;
  } pio_ports_t;

  typedef struct packed {
    logic enable;
    logic [3:0] chan;
  } pio_conv_t;

endpackage : pio_pkg

/* src/pio_ports.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// - nibble port data 0x01, direction 0x05, bits 7:4
// - analog port data 0x02, direction 0x06
// - timer port data 0x03, direction 0x07
// - timer bit6 bidirectional, bit7 input only
// - general port data 0x00, direction 0x04
// - direction one drives latch, zero floats
// - reset clears directions, keeps data latches
// - direction registers read back as written, unused nibble and timer bits as zero
// - output pins read back latch value
// - input pins store writes, read pin level
// - serial pins general only when serial off
// - timer port writes unguarded against timer
// - converter off leaves analog port general
// - converter on takes pins 6,7 as references
// - selected channel pin forced analog input
// - unselected analog pins stay general io
// - selected channel 0-5 pin reads zero
module pio_ports (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_interface_enable,
  input wire logic serial_tx_level,
  input wire logic timer_compare_enable,
  input wire logic timer_compare_level,
  input wire pio_pkg::pio_ports_t pin_in,
  output pio_pkg::pio_ports_t pin_out,
  output pio_pkg::pio_ports_t pin_oe,
  output logic [7:0] analog_select,
  output logic converter_enable
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pio_pkg::pio_ports_t sync1_ff, sync2_ff;
  pio_pkg::pio_ports_t nxt_sync1, nxt_sync2;

  always_comb begin
    nxt_sync1 = pin_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // latches have no reset; they power up unknown and survive rst
  pio_pkg::pio_ports_t data_ff, nxt_data;
  pio_pkg::pio_ports_t dir_ff, nxt_dir;
  pio_pkg::pio_conv_t conv_ff, nxt_conv;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  logic setup;
  logic [2:0] idx;
  logic map_hit, conv_hit;
  logic [7:0] wbyte;
  logic [7:0] sel_onehot;
  logic [7:0] ana_taken;
  pio_pkg::pio_ports_t rd_pins;

  always_comb begin
    setup = psel && !penable;
    idx = paddr[4:2];
    map_hit = (paddr[11:5] == pio_pkg::IDX_ADDR_HI_MAP[6:0]) && (paddr[1:0] == 2'h0);
    conv_hit = (paddr[11:5] == pio_pkg::IDX_ADDR_HI_CONV[6:0]) && (paddr[1:0] == 2'h0)
      && (idx == pio_pkg::IDX_CONV_CTL);
    wbyte = pwdata[7:0];
    sel_onehot = pio_pkg::ZERO8;
    if (conv_ff.chan < pio_pkg::ANA_PIN_CHANS) begin
      sel_onehot[conv_ff.chan[2:0]] = 1'b1;
    end
    // references and selected channel leave port control
    ana_taken = conv_ff.enable ? (pio_pkg::ANA_REF_MASK | sel_onehot) : pio_pkg::ZERO8;
  end

  always_comb begin
    nxt_data = data_ff;
    nxt_dir = dir_ff;
    nxt_conv = conv_ff;
    // answers are given in the setup cycle's next edge: zero wait states
    nxt_pready = setup;
    nxt_pslverr = setup && !(map_hit || conv_hit);
    nxt_prdata = pio_pkg::ZERO32;
    if (psel && penable && pready_ff && pwrite) begin
      if (map_hit) begin
        case (idx)
          pio_pkg::IDX_GEN_DATA: nxt_data.gen = wbyte;
          pio_pkg::IDX_NIB_DATA: nxt_data.nib = wbyte & pio_pkg::NIB_MASK;
          pio_pkg::IDX_ANA_DATA: nxt_data.ana = wbyte;
          pio_pkg::IDX_TMR_DATA: nxt_data.tmr = wbyte & pio_pkg::TMR_MASK;
          pio_pkg::IDX_GEN_DIR: nxt_dir.gen = wbyte;
          pio_pkg::IDX_NIB_DIR: nxt_dir.nib = wbyte & pio_pkg::NIB_MASK;
          pio_pkg::IDX_ANA_DIR: nxt_dir.ana = wbyte;
          pio_pkg::IDX_TMR_DIR: nxt_dir.tmr = wbyte & pio_pkg::TMR_DIR_MASK;
          default: nxt_dir = dir_ff;
        endcase
      end else if (conv_hit) begin
        nxt_conv.enable = pwdata[pio_pkg::CONV_EN_BIT];
        nxt_conv.chan = pwdata[3:0];
      end
    end
    if (setup && !pwrite) begin
      if (map_hit) begin
        case (idx)
          pio_pkg::IDX_GEN_DATA: nxt_prdata[7:0] = rd_pins.gen;
          pio_pkg::IDX_NIB_DATA: nxt_prdata[7:0] = rd_pins.nib;
          pio_pkg::IDX_ANA_DATA: nxt_prdata[7:0] = rd_pins.ana;
          pio_pkg::IDX_TMR_DATA: nxt_prdata[7:0] = rd_pins.tmr;
          pio_pkg::IDX_GEN_DIR: nxt_prdata[7:0] = dir_ff.gen;
          pio_pkg::IDX_NIB_DIR: nxt_prdata[7:0] = dir_ff.nib;
          pio_pkg::IDX_ANA_DIR: nxt_prdata[7:0] = dir_ff.ana;
          pio_pkg::IDX_TMR_DIR: nxt_prdata[7:0] = dir_ff.tmr;
          default: nxt_prdata = pio_pkg::ZERO32;
        endcase
      end else if (conv_hit) begin
        nxt_prdata[pio_pkg::CONV_EN_BIT] = conv_ff.enable;
        nxt_prdata[3:0] = conv_ff.chan;
      end
    end
  end

  // read value: latch for outputs, pin for inputs
  always_comb begin
    rd_pins = (data_ff & dir_ff) | (sync2_ff & ~dir_ff);
    rd_pins.nib = rd_pins.nib & pio_pkg::NIB_MASK;
    rd_pins.tmr = (rd_pins.tmr & pio_pkg::TMR_MASK) & ~dir_ff.tmr | (data_ff.tmr & dir_ff.tmr);
    if (conv_ff.enable) begin
      rd_pins.ana = rd_pins.ana & ~sel_onehot;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_ff <= '0;
      conv_ff <= '0;
      prdata_ff <= pio_pkg::ZERO32;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      dir_ff <= nxt_dir;
      conv_ff <= nxt_conv;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // no reset here on purpose: latches keep contents through rst
  always_ff @(posedge core_clk) begin
    data_ff <= nxt_data;
  end

  // ****************************************
  // pin drivers
  // ****************************************
  pio_pkg::pio_ports_t out_ff, nxt_out;
  pio_pkg::pio_ports_t oe_ff, nxt_oe;
  logic [7:0] asel_ff, nxt_asel;

  always_comb begin
    nxt_out = data_ff;
    nxt_oe = dir_ff;
    nxt_oe.tmr = dir_ff.tmr & pio_pkg::TMR_DIR_MASK;
    nxt_oe.nib = dir_ff.nib & pio_pkg::NIB_MASK;
    // serial owns bits 4,5 when on; registers stay writable
    if (serial_interface_enable) begin
      nxt_out.nib[4] = serial_tx_level;
      nxt_oe.nib[4] = 1'b1;
      nxt_oe.nib[5] = 1'b0;
    end
    // compare output may collide with port writes; left unguarded
    if (timer_compare_enable) begin
      nxt_out.tmr[6] = timer_compare_level;
      nxt_oe.tmr[6] = 1'b1;
    end
    nxt_oe.ana = dir_ff.ana & ~ana_taken;
    nxt_asel = ana_taken;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_ff <= '0;
      oe_ff <= '0;
      asel_ff <= pio_pkg::ZERO8;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      asel_ff <= nxt_asel;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign analog_select = asel_ff;
  assign converter_enable = conv_ff.enable;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************
  // assertions
  // ****************************************
  property p_dir_reset;
    @(posedge core_clk) $fell(rst) |-> (dir_ff == '0) && (pin_oe == '0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins driven after reset");

  property p_tmr7_input;
    @(posedge core_clk) disable iff (rst) !pin_oe.tmr[7];
  endproperty
  a_tmr7_input: assert property (p_tmr7_input) else $error("timer bit7 driven");

  property p_nib_low;
    @(posedge core_clk) disable iff (rst) pin_oe.nib[3:0] == 4'h0;
  endproperty
  a_nib_low: assert property (p_nib_low) else $error("nibble low bits driven");

  property p_refs_taken;
    @(posedge core_clk) disable iff (rst) conv_ff.enable |=> (pin_oe.ana[7:6] == 2'h0);
  endproperty
  a_refs_taken: assert property (p_refs_taken) else $error("reference pins driven");

  property p_oe_follow;
    @(posedge core_clk) disable iff (rst)
      (!conv_ff.enable && $stable(conv_ff.enable)) |=> (pin_oe.ana == $past(dir_ff.ana));
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("analog port oe wrong");

  property p_drive_latch;
    @(posedge core_clk) disable iff (rst)
      (dir_ff.gen != pio_pkg::ZERO8) |=> (pin_out.gen == $past(data_ff.gen));
  endproperty
  a_drive_latch: assert property (p_drive_latch) else $error("general pins not latch");

  property p_read_zero;
    @(posedge core_clk) disable iff (rst)
      (setup && !pwrite && map_hit && idx == pio_pkg::IDX_ANA_DATA && conv_ff.enable
       && conv_ff.chan < pio_pkg::ANA_PIN_CHANS) |=> (prdata[conv_ff.chan[2:0]] == 1'b0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("selected channel read not zero");

  property p_dir_read;
    @(posedge core_clk) disable iff (rst)
      (setup && !pwrite && map_hit && idx == pio_pkg::IDX_GEN_DIR) |=> (prdata[7:0] == $past(dir_ff.gen));
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

  property p_ready;
    @(posedge core_clk) disable iff (rst) (psel && !penable) |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");

  property p_nib_data_low;
    @(posedge core_clk) disable iff (rst)
      (psel && penable && pready && pwrite && map_hit && idx == pio_pkg::IDX_NIB_DATA)
      |=> (data_ff.nib[3:0] == 4'h0);
  endproperty
  a_nib_data_low: assert property (p_nib_data_low) else $error("nibble low data stored");

  property p_tmr_dir_mask;
    @(posedge core_clk) disable iff (rst)
      (dir_ff.tmr & ~pio_pkg::TMR_DIR_MASK) == pio_pkg::ZERO8;
  endproperty
  a_tmr_dir_mask: assert property (p_tmr_dir_mask) else $error("timer dir bit out of range");

  property p_nib_dir_mask;
    @(posedge core_clk) disable iff (rst)
      (dir_ff.nib & ~pio_pkg::NIB_MASK) == pio_pkg::ZERO8;
  endproperty
  a_nib_dir_mask: assert property (p_nib_dir_mask) else $error("nibble dir low bits set");

  property p_sel_input;
    @(posedge core_clk) disable iff (rst)
      (conv_ff.enable && conv_ff.chan < pio_pkg::ANA_PIN_CHANS)
      |=> ((pin_oe.ana & $past(sel_onehot)) == pio_pkg::ZERO8);
  endproperty
  a_sel_input: assert property (p_sel_input) else $error("selected channel pin driven");

  property p_unsel_general;
    @(posedge core_clk) disable iff (rst)
      (conv_ff.enable && conv_ff.chan >= pio_pkg::ANA_PIN_CHANS)
      |=> (pin_oe.ana[5:0] == $past(dir_ff.ana[5:0]));
  endproperty
  a_unsel_general: assert property (p_unsel_general) else $error("free analog pins not general");

  property p_oe_gen;
    @(posedge core_clk) disable iff (rst) 1'b1 |=> (pin_oe.gen == $past(dir_ff.gen));
  endproperty
  a_oe_gen: assert property (p_oe_gen) else $error("general oe not direction");

  property p_ser_pins;
    @(posedge core_clk) disable iff (rst)
      serial_interface_enable |=> (pin_oe.nib[4] && !pin_oe.nib[5]);
  endproperty
  a_ser_pins: assert property (p_ser_pins) else $error("serial pins not handed over");

  property p_tmr_cmp;
    @(posedge core_clk) disable iff (rst)
      timer_compare_enable
      |=> (pin_oe.tmr[6] && (pin_out.tmr[6] == $past(timer_compare_level)));
  endproperty
  a_tmr_cmp: assert property (p_tmr_cmp) else $error("compare output not on pin");

  property p_read_latch;
    @(posedge core_clk) disable iff (rst)
      (setup && !pwrite && map_hit && idx == pio_pkg::IDX_GEN_DATA && (&dir_ff.gen))
      |=> (prdata[7:0] == $past(data_ff.gen));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("output pin read not latch");

  property p_read_pin;
    @(posedge core_clk) disable iff (rst)
      (setup && !pwrite && map_hit && idx == pio_pkg::IDX_GEN_DATA && dir_ff.gen == pio_pkg::ZERO8)
      |=> (prdata[7:0] == $past(sync2_ff.gen));
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input pin read not level");

  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      (setup && !(map_hit || conv_hit)) |=> (pslverr && (prdata == pio_pkg::ZERO32));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_write: cover property (@(posedge core_clk) psel && penable && pready && pwrite && map_hit);
  c_conv_on: cover property (@(posedge core_clk) conv_ff.enable && conv_ff.chan == 4'h2);
  c_out: cover property (@(posedge core_clk) pin_oe.gen == 8'hff);
  c_serial: cover property (@(posedge core_clk) serial_interface_enable && pin_oe.nib[4]);
  c_chan_ref: cover property (@(posedge core_clk) conv_ff.enable && conv_ff.chan >= 4'h6);

endmodule : pio_ports

/* verif/pio_pins_model.sv */
`timescale 1ns/1ns
// ****************************************
// board side of the package pins
// ****************************************
module pio_pins_model (
  input wire pio_pkg::pio_ports_t pin_out,
  input wire pio_pkg::pio_ports_t pin_oe,
  input wire pio_pkg::pio_ports_t board,
  output pio_pkg::pio_ports_t pin_in
);
  // released pins fall to the board level, never to the last driven value
  assign pin_in = pio_pkg::pio_ports_t'((pin_out & pin_oe) | (board & ~pin_oe));
endmodule : pio_pins_model

/* verif/pio_ports_bench.sv */
`timescale 1ns/1ns
module pio_ports_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ser_en = 1'b0;
  logic ser_tx = 1'b0;
  logic tmr_en = 1'b0;
  logic tmr_lvl = 1'b0;
  logic [7:0] ana_sel;
  logic conv_en;
  logic [31:0] rd;
  logic err;
  pio_pkg::pio_ports_t pin_in, pin_out, pin_oe;
  pio_pkg::pio_ports_t board = 32'h0000_0000;
  int n_errors = 0;
  int samples_checked = 0;
  pio_ports i_pio_ports (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_interface_enable(ser_en), .serial_tx_level(ser_tx),
    .timer_compare_enable(tmr_en), .timer_compare_level(tmr_lvl), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .analog_select(ana_sel), .converter_enable(conv_en));
  pio_pins_model i_pio_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .board(board),
    .pin_in(pin_in));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : ck
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdck(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    ck(nm, rd, exp);
  endtask : rdck
  // pins lag the registers by one clock, reads lag the pins by two
  task settle;
    repeat (4) @(posedge core_clk);
  endtask : settle
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    for (int i = 4; i < 8; i++) rdck("dir_after_reset", 12'(i * 4), 32'h0);
    ck("oe_after_reset", pin_oe, 32'h0);
  endtask : t_reset
  task t_general;
    board.gen <= 8'h3c;
    apb(1'b1, 12'h000, 32'h0000_00a5);
    settle();
    rdck("gen_data_input", 12'h000, 32'h3c);
    apb(1'b1, 12'h010, 32'h0000_00ff);
    settle();
    ck("gen_out", pin_out.gen, 32'ha5);
    ck("gen_oe", pin_oe.gen, 32'hff);
    rdck("gen_data_output", 12'h000, 32'ha5);
    rdck("gen_dir", 12'h010, 32'hff);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 ck("gen_oe_reset", pin_oe.gen, 32'h0);
    apb(1'b1, 12'h010, 32'h0000_00ff);
    settle();
    ck("gen_latch_kept", pin_out.gen, 32'ha5);
  endtask : t_general
  task t_nib_tmr;
    apb(1'b1, 12'h004, 32'h0000_00ff);
    apb(1'b1, 12'h014, 32'h0000_00ff);
    rdck("nib_dir", 12'h014, 32'hf0);
    rdck("nib_data", 12'h004, 32'hf0);
    settle();
    ck("nib_oe", pin_oe.nib, 32'hf0);
    ser_en <= 1'b1;
    settle();
    ck("nib_oe_serial", pin_oe.nib, 32'hd0);
    rdck("nib_dir_serial", 12'h014, 32'hf0);
    rdck("nib_data_serial", 12'h004, 32'hf0);
    ser_en <= 1'b0;
    board.tmr <= 8'h80;
    apb(1'b1, 12'h00c, 32'h0000_00ff);
    apb(1'b1, 12'h01c, 32'h0000_00ff);
    rdck("tmr_dir", 12'h01c, 32'h40);
    settle();
    ck("tmr_oe", pin_oe.tmr, 32'h40);
    rdck("tmr_data", 12'h00c, 32'hc0);
    tmr_en <= 1'b1;
    settle();
    ck("tmr_cmp_oe", pin_oe.tmr, 32'h40);
    ck("tmr_cmp_out", pin_out.tmr[6], 32'h0);
    rdck("tmr_cmp_latch", 12'h00c, 32'hc0);
    tmr_en <= 1'b0;
  endtask : t_nib_tmr
  task t_analog;
    apb(1'b1, 12'h008, 32'h0000_00ff);
    apb(1'b1, 12'h018, 32'h0000_00ff);
    settle();
    ck("ana_oe_off", pin_oe.ana, 32'hff);
    apb(1'b1, 12'h020, 32'h0000_0022);
    settle();
    ck("ana_oe_on", pin_oe.ana, 32'h3b);
    ck("ana_select", ana_sel, 32'hc4);
    ck("conv_en", conv_en, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    ck("ana_read_chan", rd & 32'h3f, 32'h3b);
    apb(1'b1, 12'h020, 32'h0000_0028);
    settle();
    ck("ana_select_ref", ana_sel, 32'hc0);
    ck("ana_oe_ref", pin_oe.ana, 32'h3f);
    rdck("ana_read_ref", 12'h008, 32'hff);
    apb(1'b1, 12'h018, 32'h0000_00fb);
    apb(1'b1, 12'h020, 32'h0000_0000);
    settle();
    ck("ana_oe_back", pin_oe.ana, 32'hfb);
    apb(1'b0, 12'h040, 32'h0);
    ck("unmapped_err", err, 32'h1);
    ck("unmapped_data", rd, 32'h0);
  endtask : t_analog
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_general();
    t_nib_tmr();
    t_analog();
    stop_test();
  end
  // whole run needs well under a thousand clocks
  initial begin
    #300000;
    n_errors++;
    stop_test();
  end
endmodule : pio_ports_bench
